/* File: anrb_cfg.svh */
// Offsets, field positions, reset values and timing counts of the negotiation result bank
`ifndef ANRB_CFG_SVH
`define ANRB_CFG_SVH

`define ANRB_ADDR_LP_LOW 16'h020B
`define ANRB_ADDR_LP_MID 16'h020C
`define ANRB_ADDR_LP_TOP 16'h020D
`define ANRB_ADDR_LOC_ADV 16'h020E
`define ANRB_ADDR_LP_ABL 16'h020F
`define ANRB_ADDR_FORCE 16'h8000
`define ANRB_ADDR_STATUS 16'h8001

`define ANRB_RST_WORD 16'h0000
`define ANRB_RST_LONG_REACH 1'h1
`define ANRB_RST_ENERGY 1'h0

`define ANRB_ADV_LONG_BIT 15
`define ANRB_ADV_EEE_BIT 14
`define ANRB_ADV_HI_ABL_BIT 13
`define ANRB_ADV_HI_REQ_BIT 12
`define ANRB_LP_SR_FD_BIT 7
`define ANRB_LP_SR_HD_BIT 6
`define ANRB_FORCE_EN_BIT 0
`define ANRB_ST_NP_RX_BIT 10
`define ANRB_ST_INC_BIT 9
`define ANRB_ST_TXLVL_MSB 8
`define ANRB_ST_TXLVL_LSB 7
`define ANRB_ST_MS_MSB 6
`define ANRB_ST_MS_LSB 5
`define ANRB_ST_HCD_MSB 4
`define ANRB_ST_HCD_LSB 1
`define ANRB_ST_GOOD_BIT 0

`define ANRB_STRAP_SETTLE 3'h4

`endif

/* File: anrb_pkg.sv */
// Types shared by the negotiation result bank
`default_nettype none
package anrb_pkg;
  typedef logic [15:0] anrb_word_t;
  typedef enum logic [2:0] {
    ANRB_STRAP_WAIT = 3'h1,
    ANRB_STRAP_LOAD = 3'h2,
    ANRB_STRAP_RUN = 3'h4
  } anrb_strap_e;
endpackage : anrb_pkg
`default_nettype wire

/* File: anrb_sync3.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`default_nettype none
module anrb_sync3 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= 1'h0;
      s2 <= 1'h0;
      s3 <= 1'h0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level <= 1'h0;
    else if (s2 == s3)
      level <= s3;
  end
endmodule : anrb_sync3
`default_nettype wire

/* File: anrb_snap.sv */
// Sixteen-bit holding register loaded on a capture strobe
`include "anrb_cfg.svh"
`default_nettype none
module anrb_snap (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic cap,
  input wire anrb_pkg::anrb_word_t d,
  output anrb_pkg::anrb_word_t q
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= `ANRB_RST_WORD;
    else if (clr)
      q <= `ANRB_RST_WORD;
    else if (cap)
      q <= d;
  end
endmodule : anrb_snap
`default_nettype wire

/* File: anrb_bank.sv */
// Negotiation result register bank: partner page snapshot, ability mirrors, force mode, status
//
// Notes on behaviour
// (RULE1) Capture top word when low word read
// (RULE2) Top word read returns captured snapshot
// (RULE3) Advert bit 15 shared, reset one
// (RULE4) Advert bit 14 read-only energy mirror
// (RULE5) Advert bits 13:12 writable, reset from straps
// (RULE6) Partner bits 15:12 read-only mirrors
// (RULE7) Partner bits 7:6 short-reach duplex abilities
// (RULE8) Forced only when negotiation off, bit set
// (RULE9) Page request flag held until status read
// (RULE10) Incompatible flag set on good-check entry
// (RULE11) Bits 8:7 transmit level resolution
// (RULE12) Bits 6:5 master/slave resolution
// (RULE13) Bits 4:1 common technology code
// (RULE14) Bit 0 negotiation transmission done
// (RULE15) Low word read snapshots mid word too
// (RULE16) Read-only writes ignored, reserved read zero
`include "anrb_cfg.svh"
`default_nettype none
module anrb_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic an_reset,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire anrb_pkg::anrb_word_t reg_wdata,
  output anrb_pkg::anrb_word_t reg_rdata,
  output logic reg_rvalid,
  output logic reg_err,
  input wire anrb_pkg::anrb_word_t partner_next_page_low_word,
  input wire anrb_pkg::anrb_word_t partner_next_page_mid_word,
  input wire anrb_pkg::anrb_word_t partner_unformatted_field_two,
  input wire logic main_adv_wr,
  input wire logic main_adv_wdata,
  input wire logic local_energy_saving_ability,
  input wire logic strap_high_swing_ability_pin,
  input wire logic strap_high_swing_request_pin,
  input wire logic partner_long_reach_ability,
  input wire logic partner_energy_saving_ability,
  input wire logic partner_high_swing_ability,
  input wire logic partner_high_swing_request,
  input wire logic partner_short_reach_full_duplex,
  input wire logic partner_short_reach_half_duplex,
  input wire logic negotiation_enable,
  input wire logic partner_page_request_pulse,
  input wire logic good_check_entry,
  input wire logic incompatible_link_flag,
  input wire logic [1:0] swing_resolution_result,
  input wire logic [1:0] role_resolution_result,
  input wire logic [3:0] common_technology_code,
  input wire logic negotiation_done_flag,
  output logic local_long_reach_ability,
  output logic local_high_swing_ability,
  output logic local_high_swing_request,
  output logic forced_mode_enable,
  output logic forced_mode_active
);
  anrb_pkg::anrb_word_t mid_snap;
  anrb_pkg::anrb_word_t top_snap;
  anrb_pkg::anrb_word_t next_rdata;
  anrb_pkg::anrb_strap_e strap_state;
  logic [2:0] settle_cnt;
  logic strap_abl;
  logic strap_req;
  logic next_hit;
  logic rd_low;
  logic wr_adv;
  logic wr_force;
  logic rd_status;
  logic page_req_flag;
  logic inc_link;
  logic load_strap;
  logic next_err;

  assign rd_low = reg_rd && (reg_addr == `ANRB_ADDR_LP_LOW);
  assign wr_adv = reg_wr && (reg_addr == `ANRB_ADDR_LOC_ADV);
  assign wr_force = reg_wr && (reg_addr == `ANRB_ADDR_FORCE);
  assign rd_status = reg_rd && (reg_addr == `ANRB_ADDR_STATUS);
  assign load_strap = (strap_state == anrb_pkg::ANRB_STRAP_LOAD);

  // Snapshot of the partner page upper words, taken only on a low-word read
  anrb_snap u_mid_snap (
    .clk(clk),
    .rst_n(rst_n),
    .clr(an_reset),
    .cap(rd_low), // RULE15
    .d(partner_next_page_mid_word),
    .q(mid_snap)
  );

  anrb_snap u_top_snap (
    .clk(clk),
    .rst_n(rst_n),
    .clr(an_reset),
    .cap(rd_low), // RULE1
    .d(partner_unformatted_field_two),
    .q(top_snap)
  );

  // Strap pins come from outside the clock domain
  anrb_sync3 u_sync_abl (
    .clk(clk),
    .rst_n(rst_n),
    .pin(strap_high_swing_ability_pin),
    .level(strap_abl)
  );

  anrb_sync3 u_sync_req (
    .clk(clk),
    .rst_n(rst_n),
    .pin(strap_high_swing_request_pin),
    .level(strap_req)
  );

  // Straps are taken after the synchroniser has settled, never under the async reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_state <= anrb_pkg::ANRB_STRAP_WAIT;
      settle_cnt <= 3'h0;
    end
    else if (an_reset)
    begin
      strap_state <= anrb_pkg::ANRB_STRAP_LOAD;
      settle_cnt <= 3'h0;
    end
    else
    begin
      case (strap_state)
        anrb_pkg::ANRB_STRAP_WAIT:
        begin
          settle_cnt <= settle_cnt + 3'h1;
          if (settle_cnt == `ANRB_STRAP_SETTLE)
            strap_state <= anrb_pkg::ANRB_STRAP_LOAD;
        end
        anrb_pkg::ANRB_STRAP_LOAD:
          strap_state <= anrb_pkg::ANRB_STRAP_RUN;
        anrb_pkg::ANRB_STRAP_RUN:
          strap_state <= anrb_pkg::ANRB_STRAP_RUN;
        default:
          strap_state <= anrb_pkg::ANRB_STRAP_WAIT;
      endcase
    end
  end

  // A software write in the load cycle wins over the strap value
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      local_high_swing_ability <= 1'h0;
    else if (wr_adv)
      local_high_swing_ability <= reg_wdata[`ANRB_ADV_HI_ABL_BIT]; // RULE5
    else if (load_strap)
      local_high_swing_ability <= strap_abl; // RULE5
  end

  // Same priority for the request bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      local_high_swing_request <= 1'h0;
    else if (wr_adv)
      local_high_swing_request <= reg_wdata[`ANRB_ADV_HI_REQ_BIT]; // RULE5
    else if (load_strap)
      local_high_swing_request <= strap_req; // RULE5
  end

  // One bit of state behind two addresses; the local write wins a same-cycle clash
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      local_long_reach_ability <= `ANRB_RST_LONG_REACH;
    else if (an_reset)
      local_long_reach_ability <= `ANRB_RST_LONG_REACH;
    else if (wr_adv)
      local_long_reach_ability <= reg_wdata[`ANRB_ADV_LONG_BIT]; // RULE3
    else if (main_adv_wr)
      local_long_reach_ability <= main_adv_wdata; // RULE3
  end

  // Only bit 0 is kept; the rest of the word is dropped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      forced_mode_enable <= 1'h0;
    else if (an_reset)
      forced_mode_enable <= 1'h0;
    else if (wr_force)
      forced_mode_enable <= reg_wdata[`ANRB_FORCE_EN_BIT]; // RULE16
  end

  // Negotiation enable overrides the force bit; registered, so it lags by one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      forced_mode_active <= 1'h0;
    else if (an_reset)
      forced_mode_active <= 1'h0;
    else
      forced_mode_active <= forced_mode_enable && !negotiation_enable; // RULE8
  end

  // Latched-high flag: a new request in the clearing read cycle survives
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      page_req_flag <= 1'h0;
    else if (an_reset)
      page_req_flag <= 1'h0;
    else if (partner_page_request_pulse)
      page_req_flag <= 1'h1; // RULE9
    else if (rd_status)
      page_req_flag <= 1'h0; // RULE9
  end

  // Resolution result held from good-check entry until the next one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      inc_link <= 1'h0;
    else if (an_reset)
      inc_link <= 1'h0;
    else if (good_check_entry)
      inc_link <= incompatible_link_flag; // RULE10
  end

  // Read multiplexer; unlisted bits stay zero
  always_comb
  begin
    next_rdata = `ANRB_RST_WORD;
    next_hit = 1'h1;
    case (reg_addr)
      `ANRB_ADDR_LP_LOW:
        next_rdata = partner_next_page_low_word;
      `ANRB_ADDR_LP_MID:
        next_rdata = mid_snap; // RULE15
      `ANRB_ADDR_LP_TOP:
        next_rdata = top_snap; // RULE2
      `ANRB_ADDR_LOC_ADV:
      begin
        next_rdata[`ANRB_ADV_LONG_BIT] = local_long_reach_ability; // RULE3
        next_rdata[`ANRB_ADV_EEE_BIT] = local_energy_saving_ability; // RULE4
        next_rdata[`ANRB_ADV_HI_ABL_BIT] = local_high_swing_ability; // RULE5
        next_rdata[`ANRB_ADV_HI_REQ_BIT] = local_high_swing_request; // RULE5
      end
      `ANRB_ADDR_LP_ABL:
      begin
        next_rdata[`ANRB_ADV_LONG_BIT] = partner_long_reach_ability; // RULE6
        next_rdata[`ANRB_ADV_EEE_BIT] = partner_energy_saving_ability; // RULE6
        next_rdata[`ANRB_ADV_HI_ABL_BIT] = partner_high_swing_ability; // RULE6
        next_rdata[`ANRB_ADV_HI_REQ_BIT] = partner_high_swing_request; // RULE6
        next_rdata[`ANRB_LP_SR_FD_BIT] = partner_short_reach_full_duplex; // RULE7
        next_rdata[`ANRB_LP_SR_HD_BIT] = partner_short_reach_half_duplex; // RULE7
      end
      `ANRB_ADDR_FORCE:
        next_rdata[`ANRB_FORCE_EN_BIT] = forced_mode_enable; // RULE16
      `ANRB_ADDR_STATUS:
      begin
        next_rdata[`ANRB_ST_NP_RX_BIT] = page_req_flag; // RULE9
        next_rdata[`ANRB_ST_INC_BIT] = inc_link; // RULE10
        next_rdata[`ANRB_ST_TXLVL_MSB:`ANRB_ST_TXLVL_LSB] = swing_resolution_result; // RULE11
        next_rdata[`ANRB_ST_MS_MSB:`ANRB_ST_MS_LSB] = role_resolution_result; // RULE12
        next_rdata[`ANRB_ST_HCD_MSB:`ANRB_ST_HCD_LSB] = common_technology_code; // RULE13
        next_rdata[`ANRB_ST_GOOD_BIT] = negotiation_done_flag; // RULE14
      end
      default:
        next_hit = 1'h0;
    endcase
  end

  // Read data is registered so a status read sees the flag before it clears
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `ANRB_RST_WORD;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // Answer strobe follows every read by one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rvalid <= 1'h0;
    else
      reg_rvalid <= reg_rd;
  end

  // Unmapped accesses are refused with a one-cycle error pulse
  assign next_err = (reg_rd || reg_wr) && !next_hit; // RULE16

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_err <= 1'h0;
    else
      reg_err <= next_err;
  end
endmodule : anrb_bank
`default_nettype wire

/* File: anrb_far_end.sv */
// Far-side model: received pages and arbitration results derived from one seed word
`default_nettype none
module anrb_far_end (
  input wire logic [15:0] seed,
  input wire logic np_go,
  input wire logic gc_go,
  output anrb_pkg::anrb_word_t partner_next_page_low_word,
  output anrb_pkg::anrb_word_t partner_next_page_mid_word,
  output anrb_pkg::anrb_word_t partner_unformatted_field_two,
  output logic partner_long_reach_ability,
  output logic partner_energy_saving_ability,
  output logic partner_high_swing_ability,
  output logic partner_high_swing_request,
  output logic partner_short_reach_full_duplex,
  output logic partner_short_reach_half_duplex,
  output logic partner_page_request_pulse,
  output logic good_check_entry,
  output logic incompatible_link_flag,
  output logic [1:0] swing_resolution_result,
  output logic [1:0] role_resolution_result,
  output logic [3:0] common_technology_code,
  output logic negotiation_done_flag
);
  // The words differ unless the seed's two bytes are equal or complementary, so a stale snapshot shows up
  assign partner_next_page_low_word = seed;
  assign partner_next_page_mid_word = ~seed;
  assign partner_unformatted_field_two = {seed[7:0], seed[15:8]};
  assign {partner_long_reach_ability, partner_energy_saving_ability,
    partner_high_swing_ability, partner_high_swing_request,
    partner_short_reach_full_duplex, partner_short_reach_half_duplex} = seed[15:10];
  assign partner_page_request_pulse = np_go;
  assign good_check_entry = gc_go;
  assign incompatible_link_flag = seed[9];
  // Only legal level codes: 0, 2 or 3
  assign swing_resolution_result = {seed[8], seed[8] & seed[7]};
  assign role_resolution_result = seed[6:5];
  assign common_technology_code = {3'h0, seed[1]};
  assign negotiation_done_flag = seed[0];
endmodule : anrb_far_end
`default_nettype wire

/* File: anrb_bank_properties.sv */
// Port checker for the negotiation result bank
`default_nettype none
module anrb_bank_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic an_reset,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire anrb_pkg::anrb_word_t reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_err,
  input wire anrb_pkg::anrb_word_t partner_next_page_low_word,
  input wire anrb_pkg::anrb_word_t partner_unformatted_field_two,
  input wire logic partner_page_request_pulse,
  input wire logic good_check_entry,
  input wire logic incompatible_link_flag
);
  logic lo_rd, st_rd, np_q, inc_q;
  anrb_pkg::anrb_word_t top_q;
  assign lo_rd = reg_rd && reg_addr == 16'h020B;
  assign st_rd = reg_rd && reg_addr == 16'h8001;
  // Shadow of the snapshot and of the two held status bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {np_q, inc_q, top_q} <= '0;
    else if (an_reset)
      {np_q, inc_q, top_q} <= '0;
    else
    begin
      np_q <= partner_page_request_pulse || (np_q && !st_rd);
      inc_q <= good_check_entry ? incompatible_link_flag : inc_q;
      top_q <= lo_rd ? partner_unformatted_field_two : top_q;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  top_snap_a: assert property (
    reg_rd && reg_addr == 16'h020D |=> reg_rdata == $past(top_q))
    else $error("top word not the snapshot");
  low_live_a: assert property (
    lo_rd |=> reg_rdata == $past(partner_next_page_low_word))
    else $error("low word not live");
  page_flag_a: assert property (st_rd |=> reg_rdata[10] == $past(np_q))
    else $error("page request flag wrong");
  inc_held_a: assert property (st_rd |=> reg_rdata[9] == $past(inc_q))
    else $error("incompatible flag wrong");
  status_rsvd_a: assert property (st_rd |-> ##1 reg_rdata[15:11] == 5'h00)
    else $error("status reserved bits set");
  force_rsvd_a: assert property (
    reg_rd && reg_addr == 16'h8000 |=> reg_rdata[15:1] == 15'h0000)
    else $error("force reserved bits set");
  unmapped_err_a: assert property (
    reg_rd && !(reg_addr inside {[16'h020B:16'h020F], 16'h8000, 16'h8001})
    |=> reg_err && reg_rdata == 16'h0000)
    else $error("unmapped read not refused");
  flag_read_c: cover property (st_rd && np_q);
  inc_read_c: cover property (st_rd && inc_q);
  snap_c: cover property (lo_rd);
endmodule : anrb_bank_properties
bind anrb_bank anrb_bank_properties chk (.*);
`default_nettype wire

/* File: anrb_bank_bench.sv */
// Self-checking bench for the negotiation result bank
`default_nettype none
module anrb_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, an_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic main_adv_wr = 1'b0, main_adv_wdata = 1'b0, local_energy_saving_ability = 1'b0;
  logic strap_high_swing_ability_pin = 1'b1, strap_high_swing_request_pin = 1'b0;
  logic negotiation_enable = 1'b1, np_go = 1'b0, gc_go = 1'b0, reg_rvalid, reg_err;
  logic [15:0] reg_addr = 16'h0000, seed = 16'h0000, reg_wdata = 16'h0000;
  anrb_pkg::anrb_word_t reg_rdata, partner_next_page_low_word, partner_next_page_mid_word;
  anrb_pkg::anrb_word_t partner_unformatted_field_two;
  logic local_long_reach_ability, local_high_swing_ability, local_high_swing_request;
  logic forced_mode_enable, forced_mode_active, partner_long_reach_ability;
  logic partner_energy_saving_ability, partner_high_swing_ability, partner_high_swing_request;
  logic partner_short_reach_full_duplex, partner_short_reach_half_duplex;
  logic partner_page_request_pulse, good_check_entry, incompatible_link_flag;
  logic negotiation_done_flag;
  logic [1:0] swing_resolution_result, role_resolution_result;
  logic [3:0] common_technology_code;
  logic [15:0] sv [3] = '{16'hFC21, 16'h0142, 16'h01E3};
  int err_total = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  anrb_bank uut (.*);
  anrb_far_end far (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rd
  // Local energy ability follows seed bit 4 to save a separate driver
  task automatic go(input logic [15:0] v);
    @(posedge clk);
    seed <= v;
    local_energy_saving_ability <= v[4];
  endtask : go
  task automatic pulse(input logic n, input logic g, input logic a);
    @(posedge clk);
    {np_go, gc_go, an_reset} <= {n, g, a};
    @(posedge clk);
    {np_go, gc_go, an_reset} <= 3'h0;
  endtask : pulse
  task automatic final_report;
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    rd(16'h020D, 16'h0000);
    rd(16'h020E, 16'hA000);
    rd(16'h020F, 16'h0000);
    rd(16'h8001, 16'h0000);
    go(16'h1234);
    rd(16'h020B, 16'h1234);
    go(16'h5678);
    wr(16'h020D, 16'hFFFF);
    rd(16'h020D, 16'h3412);
    rd(16'h020C, 16'hEDCB);
    rd(16'h020F, 16'h5040);
    go(16'hFFFF);
    rd(16'h020F, 16'hF0C0);
    wr(16'h020E, 16'h1FFF);
    rd(16'h020E, 16'h5000);
    chk({15'h0, local_high_swing_request}, 16'h0001);
    chk({15'h0, local_high_swing_ability}, 16'h0000);
    @(posedge clk);
    main_adv_wr <= 1'b1;
    main_adv_wdata <= 1'b1;
    @(posedge clk);
    main_adv_wr <= 1'b0;
    rd(16'h020E, 16'hD000);
    chk({15'h0, local_long_reach_ability}, 16'h0001);
    wr(16'h8000, 16'hFFFF);
    rd(16'h8000, 16'h0001);
    chk({15'h0, forced_mode_enable}, 16'h0001);
    chk({15'h0, forced_mode_active}, 16'h0000);
    @(posedge clk);
    negotiation_enable <= 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0, forced_mode_active}, 16'h0001);
    wr(16'h8000, 16'h0000);
    repeat (2) @(negedge clk);
    chk({15'h0, forced_mode_active}, 16'h0000);
    foreach (sv[i])
    begin
      go(sv[i]);
      rd(16'h8001, sv[i] & 16'h01FF);
    end
    go(16'h0200);
    pulse(1'b1, 1'b1, 1'b0);
    rd(16'h8001, 16'h0600);
    go(16'h0000);
    rd(16'h8001, 16'h0200);
    pulse(1'b0, 1'b1, 1'b0);
    rd(16'h8001, 16'h0000);
    rd(16'h0210, 16'h0000);
    chk({15'h0, reg_err}, 16'h0001);
    pulse(1'b1, 1'b0, 1'b0);
    pulse(1'b0, 1'b0, 1'b1);
    rd(16'h8001, 16'h0000);
    rd(16'h020D, 16'h0000);
    rd(16'h020E, 16'hA000);
    final_report();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule : anrb_bank_bench
`default_nettype wire
